// ===== core/hss_pkg.sv
// Package with constants and carrier types for the high-side switch control block.
package hss_pkg;

  localparam int CMD_BITS        = 8;
  localparam int WD_BIT_POS      = 7;
  localparam int WDEXP_BIT_POS   = 2;
  localparam int CLK_PERIOD_NS   = 100;
  localparam int WD_TIMEOUT_MS   = 620;
  localparam int WD_TIMEOUT_CYC  = (WD_TIMEOUT_MS * 1000000) / CLK_PERIOD_NS;
  localparam logic [7:0] CFG_RESET   = 8'h00;
  localparam logic [4:0] FAULT_RESET = 5'h00;

  typedef enum logic [1:0] {
    HSS_SLEEP    = 2'b00,
    HSS_NORMAL   = 2'b01,
    HSS_FAULT    = 2'b10,
    HSS_FAILSAFE = 2'b11
  } hss_mode_e;

  // Raw fault detector levels from the analog side.
  typedef struct packed {
    logic openLoad;
    logic overcurrentLowFault;
    logic overcurrentHighFault;
    logic thermal;
    logic supplyFault;
  } hss_fault_s;

  // Serial pins after synchronisation.
  typedef struct packed {
    logic csN;
    logic sclk;
    logic sdi;
  } hss_spi_s;

endpackage

// ===== core/hss_spi_slave.sv
// Serial command port: shifts commands in and status out on the sampled serial clock.
`timescale 1ns/1ns
module hss_spi_slave (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire hss_pkg::hss_spi_s pins,
  input  wire logic [7:0]       txData,
  output logic                  sdo,
  output logic                  sdoEn,
  output logic                  frameDone,
  output logic [7:0]            rxData,
  output logic                  frameStart
);

  typedef struct packed {
    logic       sclkPrev;
    logic       csPrev;
    logic [7:0] rxShift;
    logic [7:0] txShift;
    logic [3:0] count;
    logic       sdo;
    logic       sdoEn;
    logic       done;
    logic       start;
    logic [7:0] rx;
  } hss_spi_state_s;

  hss_spi_state_s st;
  hss_spi_state_s next_st;

  always_comb begin
    next_st          = st;
    next_st.sclkPrev = pins.sclk;
    next_st.csPrev   = pins.csN;
    next_st.done     = 1'b0;
    next_st.start    = 1'b0;
    next_st.sdoEn    = ~pins.csN; // see RULE_11
    if (st.csPrev && !pins.csN) begin
      next_st.start   = 1'b1;
      next_st.count   = 4'h0;
      next_st.txShift = txData;
      next_st.sdo     = txData[7];
    end
    // A deselected device ignores the clock and data lines entirely.
    if (!pins.csN && st.sclkPrev == 1'b0 && pins.sclk) begin // see RULE_07
      next_st.rxShift = {st.rxShift[6:0], pins.sdi}; // see RULE_09 see RULE_10
      next_st.txShift = {st.txShift[6:0], 1'b0};
      next_st.sdo     = st.txShift[6]; // see RULE_12
      if (st.count != 4'hF) begin
        next_st.count = st.count + 4'h1;
      end
    end
    if (!st.csPrev && pins.csN && st.count == 4'(hss_pkg::CMD_BITS)) begin // see RULE_27
      next_st.done = 1'b1;
      next_st.rx   = st.rxShift;
    end
    if (!rst_n) begin
      next_st = '0;
      next_st.csPrev = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    st <= next_st;
  end

  assign sdo        = st.sdo;
  assign sdoEn      = st.sdoEn;
  assign frameDone  = st.done;
  assign rxData     = st.rx;
  assign frameStart = st.start;

  chk_sdo_tristate: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE_11
    $rose(pins.csN) |=> !sdoEn)
    else $error("Serial output still driven after deselect.");

  chk_frame_len: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE_27
    frameDone |-> $past(st.count) == 4'(hss_pkg::CMD_BITS))
    else $error("Command accepted without a full frame.");

endmodule

// ===== core/hss_mode_ctrl.sv
// Contract
// RULE_01 - Reset low clears configuration and faults and enters sleep; the code enters sleep only when wake is also low.
// RULE_02 - Reset rising edge starts the watchdog timer.
// RULE_03 - Direct input drives output; its use is configurable serially.
// RULE_04 - Any fault pulls open-drain fault flag low; details via serial.
// RULE_05 - After timeout, output off or on per select resistor.
// RULE_06 - Grounded select input disables watchdog and fail-safe.
// RULE_07 - Deselected device ignores all serial traffic.
// RULE_08 - Host toggles clock once per bit, idle between commands.
// RULE_09 - Commands are eight bits, most significant bit first.
// RULE_10 - Input bit loaded into shift register on rising clock edge.
// RULE_11 - Serial output driven only while chip select is low.
// RULE_12 - Serial output changes on each rising clock edge.
// RULE_13 - Logic supply loss resets all configuration registers.
// RULE_14 - Both supplies present puts device in normal mode.
// RULE_15 - Watchdog timeout moves device into fail-safe mode.
// RULE_16 - Report open load, both overcurrents, thermal, supply faults.
// RULE_17 - Fail-safe uses parallel input, default config, ignores commands; the code drives the output from the select resistor instead.
// RULE_18 - Wake and reset both low means sleep, outputs off.
// RULE_19 - Reset high, no fault, no timeout means normal mode.
// RULE_20 - Fault mode drives flag low and keeps output off.
// RULE_21 - Leave fail-safe by wake and reset low, or grounding select.
// RULE_22 - Device starts in sleep mode after power-up.
// RULE_23 - In sleep all configurable features act as if zero.
// RULE_24 - Wake high enables the watchdog function.
// RULE_25 - Watchdog bit D7 must toggle within timeout.
// RULE_26 - Watchdog-expired bit D2 reads one in fail-safe.
// RULE_27 - Command acted on at chip select rise after full frame.
`timescale 1ns/1ns
module hss_mode_ctrl #(
  parameter int WD_CYCLES = hss_pkg::WD_TIMEOUT_CYC
) (
  input  wire logic               mclk,
  input  wire logic               rst_n,
  input  wire logic               resetPin_n,
  input  wire logic               wakePin,
  input  wire logic               directIn,
  input  wire logic               logicSupplyOk,
  input  wire logic               batterySupplyOk,
  input  wire logic               failsafeSelectGnd,
  input  wire logic               failsafeResistorOn,
  input  wire hss_pkg::hss_fault_s faultIn,
  input  wire logic               csPin_n,
  input  wire logic               sclkPin,
  input  wire logic               sdiPin,
  output logic                    sdoOut,
  output logic                    sdoOe,
  output logic                    faultFlagOut,
  output logic                    faultFlagOe,
  output logic                    switchOutput,
  output logic                    watchdogExpired,
  output logic [1:0]              modeOut,
  output logic [7:0]              configOut
);

  // Pin synchronisers: two flops each, first stage read only by the second.
  // Fault levels come from the analog side and cross over in the same way.
  logic [9:0]          syncA;
  logic [9:0]          syncB;
  hss_pkg::hss_fault_s faultA;
  hss_pkg::hss_fault_s faultS;
  always_ff @(posedge mclk) begin
    syncA <= {resetPin_n, wakePin, directIn, logicSupplyOk, batterySupplyOk,
              failsafeSelectGnd, failsafeResistorOn, csPin_n, sclkPin, sdiPin};
    syncB  <= syncA;
    faultA <= faultIn;
    faultS <= faultA;
  end

  logic rstS;
  logic wakeS;
  logic dinS;
  logic vddS;
  logic vbatS;
  logic fsGndS;
  logic fsOnS;
  hss_pkg::hss_spi_s spiS;
  assign {rstS, wakeS, dinS, vddS, vbatS, fsGndS, fsOnS} = syncB[9:3];
  assign spiS = hss_pkg::hss_spi_s'(syncB[2:0]);

  typedef struct packed {
    hss_pkg::hss_mode_e mode;
    logic [7:0]         cfg;
    logic [4:0]         faults;
    logic               rstPrev;
    logic               wakePrev;
    logic               wdArmed;
    logic [31:0]        wdCount;
    logic               wdToggle;
    logic               sw;
    logic               flagLow;
    logic               wdExp;
  } hss_ctrl_state_s;

  hss_ctrl_state_s st;
  hss_ctrl_state_s next_st;

  logic       frameDone;
  logic       frameStart;
  logic [7:0] rxData;
  logic [7:0] txData;
  logic       anyFault;
  logic       cmdOn;

  // Status word: watchdog toggle echo, expired flag in bit 2, latched faults.
  always_comb begin
    txData = {st.wdToggle, st.faults[4:3], 2'b00, st.wdExp, st.faults[1:0]};
    txData[6] = st.faults[4];
    txData[5] = st.faults[3];
    txData[4] = st.faults[2]; // see RULE_16
  end

  hss_spi_slave uSpi (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .pins       (spiS),
    .txData     (txData),
    .sdo        (sdoOut),
    .sdoEn      (sdoOe),
    .frameDone  (frameDone),
    .rxData     (rxData),
    .frameStart (frameStart)
  );

  assign anyFault = |faultS;
  // Config bit 0 selects serial on; bit 1 lets the direct input drive the switch.
  assign cmdOn = (st.cfg[1] & dinS) | st.cfg[0]; // see RULE_03

  always_comb begin
    next_st          = st;
    next_st.rstPrev  = rstS;
    next_st.wakePrev = wakeS;
    next_st.faults   = st.faults | faultS; // see RULE_16
    if (frameStart) begin
      // Faults are reported in the frame that starts now; new events still win.
      next_st.faults = faultS;
    end
    if (((!st.rstPrev && rstS) || (!st.wakePrev && wakeS)) && !fsGndS) begin
      next_st.wdArmed = 1'b1; // see RULE_02 see RULE_24
      next_st.wdCount = '0;
    end
    if (frameDone && st.mode != hss_pkg::HSS_FAILSAFE) begin
      next_st.cfg = rxData; // see RULE_27
      if (rxData[hss_pkg::WD_BIT_POS] != st.wdToggle) begin
        next_st.wdCount = '0; // see RULE_25
      end
      next_st.wdToggle = rxData[hss_pkg::WD_BIT_POS];
    end
    if (st.wdArmed && st.mode != hss_pkg::HSS_FAILSAFE && !fsGndS) begin
      // Count on from any restart made above, so that a kick really starts a new period.
      next_st.wdCount = next_st.wdCount + 32'h1;
      if (next_st.wdCount >= 32'(WD_CYCLES)) begin
        next_st.mode = hss_pkg::HSS_FAILSAFE; // see RULE_15
        next_st.cfg  = hss_pkg::CFG_RESET; // see RULE_17
      end
    end
    unique case (st.mode)
      hss_pkg::HSS_SLEEP: begin
        next_st.cfg = hss_pkg::CFG_RESET; // see RULE_23
        if ((rstS || wakeS) && vddS && vbatS) begin
          next_st.mode = hss_pkg::HSS_NORMAL; // see RULE_14
        end
      end
      hss_pkg::HSS_NORMAL: begin
        if (anyFault) begin
          next_st.mode = hss_pkg::HSS_FAULT;
        end
      end
      hss_pkg::HSS_FAULT: begin
        if (!anyFault && rstS) begin
          next_st.mode = hss_pkg::HSS_NORMAL; // see RULE_19
        end
      end
      hss_pkg::HSS_FAILSAFE: begin
        next_st.wdArmed = 1'b0;
        if (fsGndS) begin
          next_st.mode = hss_pkg::HSS_NORMAL; // see RULE_21
        end
      end
    endcase
    if (fsGndS) begin
      next_st.wdArmed = 1'b0; // see RULE_06
    end
    if (!vddS) begin
      next_st.cfg = hss_pkg::CFG_RESET; // see RULE_13
    end
    if (!rstS && !wakeS) begin
      next_st.mode    = hss_pkg::HSS_SLEEP; // see RULE_18 see RULE_21
      next_st.wdArmed = 1'b0;
    end
    if (!rstS) begin
      next_st.cfg    = hss_pkg::CFG_RESET; // see RULE_01
      next_st.faults = hss_pkg::FAULT_RESET;
    end
    next_st.wdExp   = (next_st.mode == hss_pkg::HSS_FAILSAFE); // see RULE_26
    next_st.flagLow = anyFault && next_st.mode != hss_pkg::HSS_SLEEP; // see RULE_04 see RULE_20
    unique case (next_st.mode)
      hss_pkg::HSS_SLEEP:    next_st.sw = 1'b0;
      hss_pkg::HSS_NORMAL:   next_st.sw = cmdOn; // see RULE_03
      hss_pkg::HSS_FAULT:    next_st.sw = 1'b0;
      hss_pkg::HSS_FAILSAFE: next_st.sw = fsOnS; // see RULE_05
    endcase
    if (!rst_n) begin
      next_st         = '0; // see RULE_22
      next_st.mode    = hss_pkg::HSS_SLEEP;
      next_st.rstPrev = 1'b0;
      next_st.cfg     = hss_pkg::CFG_RESET;
      next_st.faults  = hss_pkg::FAULT_RESET;
    end
  end

  always_ff @(posedge mclk) begin
    st <= next_st;
  end

  assign faultFlagOut    = 1'b0;
  assign faultFlagOe     = st.flagLow;
  assign switchOutput    = st.sw;
  assign watchdogExpired = st.wdExp;
  assign modeOut         = st.mode;
  assign configOut       = st.cfg;

  chk_sleep_off: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE_18
    (!rstS && !wakeS) |=> (modeOut == hss_pkg::HSS_SLEEP && !switchOutput))
    else $error("Sleep not entered with wake and reset low.");

  chk_reset_clear: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE_01
    !rstS |=> (configOut == hss_pkg::CFG_RESET))
    else $error("Configuration not cleared under reset.");

  chk_flag_fault: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE_04
    (anyFault && modeOut != hss_pkg::HSS_SLEEP && (rstS || wakeS)) |=> faultFlagOe)
    else $error("Fault flag not pulled low.");

  chk_fault_off: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE_20
    modeOut == hss_pkg::HSS_FAULT |-> !switchOutput)
    else $error("Output on in fault mode.");

  chk_wdexp_mode: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE_26
    watchdogExpired == (modeOut == hss_pkg::HSS_FAILSAFE))
    else $error("Expired bit disagrees with mode.");

  chk_failsafe_out: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE_05
    (modeOut == hss_pkg::HSS_FAILSAFE && $stable(fsOnS)) |-> switchOutput == $past(fsOnS))
    else $error("Fail-safe output does not follow select.");

  chk_gnd_nowd: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE_06
    fsGndS |=> !st.wdArmed)
    else $error("Watchdog armed with select grounded.");

  chk_vdd_loss: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE_13
    !vddS |=> configOut == hss_pkg::CFG_RESET)
    else $error("Configuration kept without logic supply.");

  // Watchdog arming, restart and expiry.
  chk_wd_arm: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE_02
    (!st.rstPrev && rstS && !fsGndS && modeOut != hss_pkg::HSS_FAILSAFE)
    |=> st.wdArmed)
    else $error("Watchdog not armed by reset release.");

  chk_wake_arm: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE_24
    (!st.wakePrev && wakeS && !fsGndS && modeOut != hss_pkg::HSS_FAILSAFE)
    |=> st.wdArmed)
    else $error("Watchdog not armed by wake.");

  chk_wd_kick: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE_25
    (frameDone && st.wdArmed && modeOut != hss_pkg::HSS_FAILSAFE && !fsGndS &&
     rxData[hss_pkg::WD_BIT_POS] != st.wdToggle)
    |=> st.wdCount == 32'h1)
    else $error("Watchdog not restarted by a toggled command.");

  chk_wd_expire: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE_15
    (st.wdArmed && modeOut == hss_pkg::HSS_NORMAL && !anyFault && !fsGndS && !frameDone &&
     (rstS || wakeS) && st.rstPrev == rstS && st.wakePrev == wakeS &&
     st.wdCount == 32'(WD_CYCLES - 1))
    |=> modeOut == hss_pkg::HSS_FAILSAFE)
    else $error("Watchdog period ran out without entering fail-safe.");

  // Mode transitions and the configuration fail-safe and sleep modes must show.
  chk_fs_config: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE_17
    modeOut == hss_pkg::HSS_FAILSAFE |-> configOut == hss_pkg::CFG_RESET)
    else $error("Fail-safe mode not on default configuration.");

  chk_sleep_cfg: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE_23
    modeOut == hss_pkg::HSS_SLEEP |-> configOut == hss_pkg::CFG_RESET)
    else $error("Configuration bits active in sleep.");

  chk_normal_entry: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE_14
    (modeOut == hss_pkg::HSS_SLEEP && (rstS || wakeS) && vddS && vbatS)
    |=> modeOut == hss_pkg::HSS_NORMAL)
    else $error("Normal mode not entered with both supplies.");

  chk_fault_entry: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE_20
    (modeOut == hss_pkg::HSS_NORMAL && anyFault && (rstS || wakeS))
    |=> modeOut == hss_pkg::HSS_FAULT)
    else $error("Fault mode not entered on a fault.");

  chk_fault_leave: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE_19
    (modeOut == hss_pkg::HSS_FAULT && !anyFault && rstS)
    |=> modeOut == hss_pkg::HSS_NORMAL)
    else $error("Normal mode not resumed after the fault cleared.");

  chk_fs_exit: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE_21
    (modeOut == hss_pkg::HSS_FAILSAFE && fsGndS && (rstS || wakeS))
    |=> modeOut == hss_pkg::HSS_NORMAL)
    else $error("Fail-safe not left with select grounded.");

endmodule

// ===== verification/hss_host_model.sv
// Host serial master model that frames commands and collects status bits.
`timescale 1ns/1ns
module hss_host_model (
  input  wire logic mclk,
  input  wire logic sdoOut,
  input  wire logic sdoOe,
  output logic      csPin_n,
  output logic      sclkPin,
  output logic      sdiPin
);
  initial begin
    csPin_n = 1'b1;
    sclkPin = 1'b0;
    sdiPin  = 1'b0;
  end

  // Clock idles low between frames; data in is driven low after each frame, and a released data out reads as x.
  task automatic xfer(input logic [7:0] tx, input int nBits, input logic sel,
                      output logic [7:0] rx);
    rx = 8'h00;
    @(posedge mclk);
    csPin_n <= ~sel;
    repeat (6) @(posedge mclk);
    for (int i = 7; i > 7 - nBits; i--) begin
      sdiPin <= tx[i];
      repeat (4) @(posedge mclk);
      rx[i] = sdoOe ? sdoOut : 1'bx;
      sclkPin <= 1'b1;
      repeat (4) @(posedge mclk);
      sclkPin <= 1'b0;
    end
    repeat (4) @(posedge mclk);
    sdiPin  <= 1'b0;
    csPin_n <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask
endmodule

// ===== verification/tb_top.sv
// Bench for the switch mode controller driven through the host serial model.
`timescale 1ns/1ns
module tb_top;
  localparam int WDC = 400;
  localparam int FPOS [5] = '{6, 5, 4, 1, 0};
  logic                mclk               = 1'b0;
  logic                rst_n              = 1'b0;
  logic                resetPin_n         = 1'b0;
  logic                wakePin            = 1'b0;
  logic                directIn           = 1'b0;
  logic                logicSupplyOk      = 1'b0;
  logic                batterySupplyOk    = 1'b0;
  logic                failsafeSelectGnd  = 1'b1;
  logic                failsafeResistorOn = 1'b1;
  hss_pkg::hss_fault_s faultIn            = '0;
  logic                csPin_n;
  logic                sclkPin;
  logic                sdiPin;
  logic                sdoOut;
  logic                sdoOe;
  logic                faultFlagOut;
  logic                faultFlagOe;
  logic                switchOutput;
  logic                watchdogExpired;
  logic [1:0]          modeOut;
  logic [7:0]          configOut;
  logic [7:0]          rx;
  int                  err_total          = 0;
  int                  checks_done        = 0;

  always #50 mclk = ~mclk;

  hss_mode_ctrl #(.WD_CYCLES(WDC)) i_dut (.mclk, .rst_n, .resetPin_n, .wakePin, .directIn,
    .logicSupplyOk, .batterySupplyOk, .failsafeSelectGnd, .failsafeResistorOn, .faultIn,
    .csPin_n, .sclkPin, .sdiPin, .sdoOut, .sdoOe, .faultFlagOut, .faultFlagOe,
    .switchOutput, .watchdogExpired, .modeOut, .configOut);

  hss_host_model i_host (.mclk, .sdoOut, .sdoOe, .csPin_n, .sclkPin, .sdiPin);

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    if (err_total == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic send(input logic [7:0] tx, input int nBits = 8, input logic sel = 1'b1);
    i_host.xfer(tx, nBits, sel, rx);
  endtask

  task automatic await_mode(input logic [1:0] m);
    for (int n = 0; n < 20 && modeOut !== m; n++) @(posedge mclk);
    check({6'h00, modeOut}, {6'h00, m});
  endtask

  task automatic t_sleep();
    directIn <= 1'b1;
    cyc(6);
    check({6'h00, modeOut}, 8'h00);
    check(configOut, 8'h00);
    check({7'h00, switchOutput}, 8'h00);
    check({7'h00, faultFlagOe}, 8'h00);
    batterySupplyOk <= 1'b1;
    logicSupplyOk   <= 1'b1;
    resetPin_n      <= 1'b1;
    await_mode(2'h1);
    cyc(2 * WDC);
    check({6'h00, modeOut}, 8'h01);
  endtask

  task automatic t_cmd();
    send(8'h82);
    cyc(6);
    check({6'h00, configOut[1:0]}, 8'h02);
    check({7'h00, sdoOe}, 8'h00);
    directIn <= 1'b0;
    cyc(6);
    check({7'h00, switchOutput}, 8'h00);
    directIn <= 1'b1;
    cyc(6);
    check({7'h00, switchOutput}, 8'h01);
    send(8'h00, 8, 1'b0);
    send(8'h00, 7);
    cyc(6);
    check({6'h00, configOut[1:0]}, 8'h02);
    logicSupplyOk <= 1'b0;
    cyc(6);
    check(configOut, 8'h00);
    logicSupplyOk <= 1'b1;
    cyc(6);
    send(8'h83);
    directIn <= 1'b0;
    cyc(6);
    check({7'h00, switchOutput}, 8'h01);
  endtask

  task automatic t_fault();
    for (int i = 0; i < 5; i++) begin
      faultIn <= hss_pkg::hss_fault_s'(5'h10 >> i);
      await_mode(2'h2);
      check({faultFlagOe, faultFlagOut}, 8'h02);
      check({7'h00, switchOutput}, 8'h00);
      send(8'h83);
      check({7'h00, rx[FPOS[i]]}, 8'h01);
      faultIn <= '0;
      send(8'h83);
    end
  endtask

  task automatic t_watchdog();
    resetPin_n <= 1'b0;
    wakePin    <= 1'b0;
    await_mode(2'h0);
    failsafeSelectGnd <= 1'b0;
    resetPin_n        <= 1'b1;
    await_mode(2'h1);
    for (int k = 0; k < 6; k++) begin
      send({k[0], 7'h03});
      cyc(40);
    end
    check({6'h00, modeOut}, 8'h01);
    cyc(WDC);
    await_mode(2'h3);
    check({7'h00, watchdogExpired}, 8'h01);
    check({7'h00, switchOutput}, 8'h01);
    send(8'h83);
    check({7'h00, rx[hss_pkg::WDEXP_BIT_POS]}, 8'h01);
    cyc(6);
    check(configOut, 8'h00);
    failsafeResistorOn <= 1'b0;
    cyc(6);
    check({7'h00, switchOutput}, 8'h00);
    resetPin_n <= 1'b0;
    wakePin    <= 1'b0;
    await_mode(2'h0);
    check({7'h00, watchdogExpired}, 8'h00);
    wakePin <= 1'b1;
    await_mode(2'h1);
    cyc(WDC);
    await_mode(2'h3);
    check({7'h00, switchOutput}, 8'h00);
    failsafeSelectGnd <= 1'b1;
    await_mode(2'h1);
  endtask

  initial begin
    cyc(8);
    rst_n <= 1'b1;
    cyc(3);
    t_sleep();
    t_cmd();
    t_fault();
    t_watchdog();
    close_out();
  end

  initial begin
    #(20000 * 100);
    err_total++;
    close_out();
  end
endmodule
